// File: unknown_frame_forward_config.sv
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "unknown_frame_forward_regs.svh"
module unknown_frame_forward_config
  import unknown_frame_forward_pkg::*;
#(
  parameter int unsigned CYC_16MS  = `PER16_MS * `CLK_KHZ,
  parameter int unsigned CYC_64MS  = `PER64_MS * `CLK_KHZ,
  parameter int unsigned CYC_256MS = `PER256_MS * `CLK_KHZ
) (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                arst_n,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [`ADDR_W-1:0]  paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic                     pslverr,
  output logic [31:0]              prdata,
  // forwarding decision
  input  wire fwd_req_t            fwd_req,
  output fwd_res_t                 fwd_res,
  // egress self-address filter
  input  wire egr_req_t            egr_req,
  input  wire logic [47:0]         self_mac,
  output logic                     self_valid,
  output logic                     self_drop,
  // egress tag insertion
  input  wire tag_req_t            tag_req,
  output logic                     tag_valid,
  output logic                     tag_insert,
  // rate limiting
  output logic                     rate_tick,
  output logic                     queue_limit_en
);

  ////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic reg_hit(
    input logic [`ADDR_W-1:0] a,
    input logic [7:0]         idx
  );
    return a == {2'h0, idx, 2'h0};
  endfunction

  // bit 3 of a register port map is reserved and never forwards; the lookup map passes through unmasked
  function automatic logic [4:0] port_map(input logic [4:0] f);
    return f & `MAP_MASK;
  endfunction

  function automatic logic [23:0] per_cyc(input logic [1:0] p);
    logic [23:0] c;
    c = 24'(CYC_256MS);
    case (p)
      `PER_16: c = 24'(CYC_16MS);
      `PER_64: c = 24'(CYC_64MS);
      default: c = 24'(CYC_256MS);
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////
  // register bus

  state_t q;
  state_t d;
  logic   hit_umc;
  logic   hit_uvid;
  logic   hit_self;
  logic   hit_rate;
  logic   hit;
  logic   wr;
  logic   setup_rd;
  logic [31:0] rd_word;

  assign hit_umc  = reg_hit(paddr, `IDX_UMC);
  assign hit_uvid = reg_hit(paddr, `IDX_UVID);
  assign hit_self = reg_hit(paddr, `IDX_SELF);
  assign hit_rate = reg_hit(paddr, `IDX_RATE);
  assign hit      = hit_umc | hit_uvid | hit_self | hit_rate;
  assign wr       = psel & penable & pwrite & pstrb[0] & hit;
  assign setup_rd = psel & ~penable & ~pwrite;

  // no wait states, unmapped access answers with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = q.rdata;

  always_comb begin
    rd_word = 32'h0;
    if (hit_umc) begin
      rd_word[`HI_MSB:`HI_LSB]   = `UMC_HI_RO;
      rd_word[`EN_BIT]           = q.umc_en;
      rd_word[`MAP_MSB:`MAP_LSB] = q.umc_map;
    end
    if (hit_uvid) begin
      rd_word[`EN_BIT]           = q.uvid_en;
      rd_word[`MAP_MSB:`MAP_LSB] = q.uvid_map;
    end
    if (hit_self) begin
      rd_word[`SELF_BIT]         = q.self_en;
      rd_word[`EN_BIT]           = q.uipm_en;
      rd_word[`MAP_MSB:`MAP_LSB] = q.uipm_map;
    end
    if (hit_rate) begin
      rd_word[`PER_MSB:`PER_LSB] = q.per;
      rd_word[`QUEUE_BIT]        = q.queue_lim;
      rd_word[`TAGSEL_BIT]       = q.tag_sel;
    end
  end

  ////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (setup_rd) begin
      d.rdata = rd_word;
    end
    if (wr && hit_umc) begin
      d.umc_en  = pwdata[`EN_BIT];
      d.umc_map = port_map(pwdata[`MAP_MSB:`MAP_LSB]);
    end
    if (wr && hit_uvid) begin
      d.uvid_en  = pwdata[`EN_BIT];
      d.uvid_map = port_map(pwdata[`MAP_MSB:`MAP_LSB]);
    end
    if (wr && hit_self) begin
      d.self_en  = pwdata[`SELF_BIT];
      d.uipm_en  = pwdata[`EN_BIT];
      d.uipm_map = port_map(pwdata[`MAP_MSB:`MAP_LSB]);
    end
    if (wr && hit_rate) begin
      d.per       = pwdata[`PER_MSB:`PER_LSB];
      d.queue_lim = pwdata[`QUEUE_BIT];
      d.tag_sel   = pwdata[`TAGSEL_BIT];
    end

    // unit period timer restarts whenever the period changes
    if (wr && hit_rate) begin
      d.cnt = '0;
    end else if (q.cnt >= per_cyc(q.per) - 24'h1) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 24'h1;
    end

    // port map choice; unknown VLAN outranks the address classes
    d.fwd.valid = fwd_req.valid;
    d.fwd.map   = fwd_req.lookup_map;
    if (fwd_req.unk_vid) begin
      if (q.uvid_en) begin
        d.fwd.map = q.uvid_map;
      end
    end else if (fwd_req.unk_ip_mcast) begin
      if (q.uipm_en) begin
        d.fwd.map = q.uipm_map;
      end
    end else if (fwd_req.unk_mcast && !fwd_req.ip_mcast) begin
      if (q.umc_en) begin
        d.fwd.map = q.umc_map;
      end
    end
    // otherwise the lookup result stands
    d.fwd.drop = fwd_req.valid && (d.fwd.map == `MAP_RST);

    // egress compare against own address
    d.self_valid = egr_req.valid;
    d.self_drop  = egr_req.valid && q.self_en
                   && (egr_req.da == self_mac);

    // tag insertion choice
    d.tag_valid = tag_req.valid;
    if (q.tag_sel) begin
      d.tag_ins = tag_req.valid
                  && tag_req.sel_map[tag_req.src];
    end else begin
      d.tag_ins = tag_req.valid && tag_req.base_ins;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q           <= '0;
      q.umc_map   <= `MAP_RST;
      q.uvid_map  <= `MAP_RST;
      q.uipm_map  <= `MAP_RST;
      q.per       <= `PER_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs

  assign fwd_res        = q.fwd;
  assign self_valid     = q.self_valid;
  assign self_drop      = q.self_drop;
  assign tag_valid      = q.tag_valid;
  assign tag_insert     = q.tag_ins;
  assign rate_tick      = q.tick;
  assign queue_limit_en = q.queue_lim;

  ////////////////////////////////////////////////////////////////
  // checks

  logic [23:0] gap_q;
  logic        per_chg_q;

  // cycles since last tick, and whether the period moved meanwhile
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap_q     <= 24'h0;
      per_chg_q <= 1'b0;
    end else begin
      gap_q <= rate_tick ? 24'h1 : gap_q + 24'h1;
      if (wr && hit_rate) begin
        per_chg_q <= 1'b1;
      end else if (rate_tick) begin
        per_chg_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_umc_map;
    fwd_req.valid && fwd_req.unk_mcast && !fwd_req.ip_mcast
      && !fwd_req.unk_vid && !fwd_req.unk_ip_mcast && q.umc_en
    |=> fwd_res.valid && fwd_res.map == ($past(q.umc_map) & `MAP_MASK);
  endproperty
  a_umc_map: assert property (p_umc_map)
    else $error("unknown multicast map not applied");

  property p_ip_excluded;
    fwd_req.valid && fwd_req.unk_mcast && fwd_req.ip_mcast
      && !fwd_req.unk_vid && !fwd_req.unk_ip_mcast
    |=> fwd_res.map == $past(fwd_req.lookup_map);
  endproperty
  a_ip_excluded: assert property (p_ip_excluded)
    else $error("ip multicast took unknown multicast map");

  property p_uvid_map;
    fwd_req.valid && fwd_req.unk_vid && q.uvid_en
    |=> fwd_res.map == $past(q.uvid_map)
        && fwd_res.drop == ($past(q.uvid_map) == 5'h00);
  endproperty
  a_uvid_map: assert property (p_uvid_map)
    else $error("unknown vlan map not applied");

  property p_map_rsvd;
    wr && hit_uvid |=> q.uvid_map[`QUEUE_BIT] == 1'b0
      && q.uvid_map == ($past(pwdata[`MAP_MSB:`MAP_LSB]) & `MAP_MASK);
  endproperty
  a_map_rsvd: assert property (p_map_rsvd)
    else $error("vlan map write wrong");

  property p_self_drop;
    egr_req.valid && q.self_en && egr_req.da == self_mac
    |=> self_valid && self_drop;
  endproperty
  a_self_drop: assert property (p_self_drop)
    else $error("own address frame not dropped");

  property p_self_pass;
    !q.self_en |=> !self_drop;
  endproperty
  a_self_pass: assert property (p_self_pass)
    else $error("frame dropped with filter off");

  property p_uipm_map;
    fwd_req.valid && !fwd_req.unk_vid && fwd_req.unk_ip_mcast
      && q.uipm_en
    |=> fwd_res.map == $past(q.uipm_map);
  endproperty
  a_uipm_map: assert property (p_uipm_map)
    else $error("unknown ip multicast map not applied");

  property p_period;
    rate_tick && !per_chg_q |-> gap_q == per_cyc(q.per);
  endproperty
  a_period: assert property (p_period)
    else $error("rate unit period wrong");

  property p_queue;
    wr && hit_rate |=> queue_limit_en == $past(pwdata[`QUEUE_BIT]);
  endproperty
  a_queue: assert property (p_queue)
    else $error("egress limit mode not taken");

  property p_tag_sel;
    tag_req.valid && q.tag_sel
    |=> tag_insert == $past(tag_req.sel_map[tag_req.src]);
  endproperty
  a_tag_sel: assert property (p_tag_sel)
    else $error("per source tag choice wrong");

  property p_tag_base;
    tag_req.valid && !q.tag_sel
    |=> tag_insert == $past(tag_req.base_ins);
  endproperty
  a_tag_base: assert property (p_tag_base)
    else $error("base tag choice wrong");

  property p_fallback;
    fwd_req.valid && fwd_req.unk_vid && !q.uvid_en
    |=> fwd_res.map == $past(fwd_req.lookup_map);
  endproperty
  a_fallback: assert property (p_fallback)
    else $error("disabled class did not use lookup");

  c_tick: cover property (rate_tick);
  c_self: cover property (self_drop);
  c_fdrop: cover property (fwd_res.valid && fwd_res.drop);
  c_wr_rd: cover property (wr ##1 setup_rd);

endmodule

// File: unknown_frame_forward_config_test.sv
`timescale 1ns/1ps
`include "unknown_frame_forward_regs.svh"
module unknown_frame_forward_config_test;
  import unknown_frame_forward_pkg::*;

  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0]  pstrb = '0;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  fwd_req_t    fwd_req = '0;
  fwd_res_t    fwd_res;
  egr_req_t    egr_req = '0;
  logic [47:0] self_mac = 48'h0A1B2C3D4E5F;
  logic        self_valid;
  logic        self_drop;
  tag_req_t    tag_req = '0;
  logic        tag_valid;
  logic        tag_insert;
  logic        rate_tick;
  logic        queue_limit_en;
  int          bad_count = 0;
  int          checks = 0;

  always #20 clock = ~clock;

  unknown_frame_forward_config #(
    .CYC_16MS (8),
    .CYC_64MS (16),
    .CYC_256MS(32)
  ) u_unknown_frame_forward_config (
    .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .fwd_req(fwd_req), .fwd_res(fwd_res), .egr_req(egr_req),
    .self_mac(self_mac), .self_valid(self_valid), .self_drop(self_drop),
    .tag_req(tag_req), .tag_valid(tag_valid), .tag_insert(tag_insert),
    .rate_tick(rate_tick), .queue_limit_en(queue_limit_en)
  );

  ////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic err);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    pstrb   <= s;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 8; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 8) begin
      bad_count++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, a, d, 4'hF, rd, e);
    chk("write error", {31'h0, e}, 32'h0);
  endtask

  task automatic rdc(input string name, input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 8'h00, 4'h0, rd, e);
    chk(name, rd, {24'h0, exp});
    chk("read error", {31'h0, e}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] rd;
    logic        e;
    rdc("umc reset", 12'h210, 8'h40);
    rdc("uvid reset", 12'h214, 8'h00);
    rdc("self reset", 12'h218, 8'h00);
    rdc("rate reset", 12'h21C, 8'h10);
    chk("queue reset", {31'h0, queue_limit_en}, 32'h0);
    wr(12'h210, 8'hFF);
    wr(12'h214, 8'hFF);
    wr(12'h218, 8'hFF);
    wr(12'h21C, 8'hFF);
    rdc("umc all", 12'h210, 8'h77);
    rdc("uvid all", 12'h214, 8'h37);
    rdc("self all", 12'h218, 8'h77);
    rdc("rate all", 12'h21C, 8'h3C);
    apb(1'b1, 12'h214, 8'h00, 4'h0, rd, e);
    rdc("uvid no strobe", 12'h214, 8'h37);
    apb(1'b0, 12'h220, 8'h00, 4'h0, rd, e);
    chk("unmapped error", {31'h0, e}, 32'h1);
    $display("test regs done");
  endtask

  task automatic fwd(input logic vid, input logic ipm, input logic mc, input logic ipf,
                     input logic [4:0] look, input logic [4:0] exp);
    @(posedge clock);
    fwd_req <= '{valid: 1'b1, unk_mcast: mc, ip_mcast: ipf, unk_vid: vid,
                 unk_ip_mcast: ipm, lookup_map: look};
    @(posedge clock);
    fwd_req <= '0;
    #1;
    chk("fwd valid", {31'h0, fwd_res.valid}, 32'h1);
    chk("fwd map", {27'h0, fwd_res.map}, {27'h0, exp});
    chk("fwd drop", {31'h0, fwd_res.drop}, {31'h0, exp == 5'h00});
  endtask

  task automatic t_fwd();
    logic [4:0] m[5] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h1F};
    for (int i = 0; i < 5; i++) begin
      wr(12'h214, {3'h1, m[i]});
      wr(12'h218, {3'h1, m[(i+1)%5]});
      wr(12'h210, {3'h1, m[(i+2)%5]});
      fwd(1, 1, 1, 0, 5'h05, m[i] & 5'h17);
      fwd(0, 1, 1, 1, 5'h05, m[(i+1)%5] & 5'h17);
      fwd(0, 0, 1, 0, 5'h05, m[(i+2)%5] & 5'h17);
      fwd(0, 0, 1, 1, 5'h05, 5'h05);
    end
    wr(12'h214, 8'h07);
    wr(12'h218, 8'h07);
    wr(12'h210, 8'h07);
    fwd(1, 0, 0, 0, 5'h06, 5'h06);
    fwd(0, 1, 0, 1, 5'h00, 5'h00);
    fwd(0, 0, 1, 0, 5'h11, 5'h11);
    $display("test forward done");
  endtask

  task automatic egr(input logic [47:0] da, input logic exp);
    @(posedge clock);
    egr_req <= '{valid: 1'b1, da: da};
    @(posedge clock);
    egr_req <= '0;
    #1;
    chk("self valid", {31'h0, self_valid}, 32'h1);
    chk("self drop", {31'h0, self_drop}, {31'h0, exp});
  endtask

  task automatic t_self();
    wr(12'h218, 8'h40);
    egr(self_mac, 1'b1);
    egr(self_mac ^ 48'h1, 1'b0);
    egr(48'h01005E000001, 1'b0);
    wr(12'h218, 8'h00);
    egr(self_mac, 1'b0);
    $display("test self filter done");
  endtask

  task automatic tag(input logic [1:0] src, input logic [3:0] sm, input logic b,
                     input logic exp);
    @(posedge clock);
    tag_req <= '{valid: 1'b1, src: src, sel_map: sm, base_ins: b};
    @(posedge clock);
    tag_req <= '0;
    #1;
    chk("tag valid", {31'h0, tag_valid}, 32'h1);
    chk("tag insert", {31'h0, tag_insert}, {31'h0, exp});
  endtask

  task automatic t_tag();
    wr(12'h21C, 8'h14);
    for (int s = 0; s < 4; s++) begin
      tag(s[1:0], 4'h5, 1'b1, s[0] == 1'b0);
      tag(s[1:0], 4'hA, 1'b0, s[0] == 1'b1);
    end
    wr(12'h21C, 8'h10);
    tag(2'h1, 4'h0, 1'b1, 1'b1);
    tag(2'h2, 4'hF, 1'b0, 1'b0);
    $display("test tag done");
  endtask

  task automatic t_rate();
    int per[4] = '{8, 16, 32, 32};
    int n;
    for (int p = 0; p < 4; p++) begin
      wr(12'h21C, {2'h0, p[1:0], p[0], 3'h0});
      // let the write edge settle before looking at the register output
      #1;
      chk("queue mode", {31'h0, queue_limit_en}, {31'h0, p[0]});
      for (n = 0; n < 100; n++) begin
        @(posedge clock);
        #1;
        if (rate_tick === 1'b1) break;
      end
      if (n == 100) begin
        bad_count++;
        print_verdict();
      end
      for (n = 1; n < 100; n++) begin
        @(posedge clock);
        #1;
        if (rate_tick === 1'b1) break;
      end
      if (n == 100) begin
        bad_count++;
        print_verdict();
      end
      chk("tick period", n, per[p]);
    end
    $display("test rate done");
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_regs();
    t_fwd();
    t_self();
    t_tag();
    t_rate();
    print_verdict();
  end
endmodule

// File: unknown_frame_forward_pkg.sv
package unknown_frame_forward_pkg;

  // frame classified by lookup, waiting for its port map
  typedef struct packed {
    logic       valid;
    logic       unk_mcast;
    logic       ip_mcast;
    logic       unk_vid;
    logic       unk_ip_mcast;
    logic [4:0] lookup_map;
  } fwd_req_t;

  typedef struct packed {
    logic       valid;
    logic       drop;
    logic [4:0] map;
  } fwd_res_t;

  // frame at an egress port
  typedef struct packed {
    logic        valid;
    logic [47:0] da;
  } egr_req_t;

  // tag decision request from an egress port
  typedef struct packed {
    logic       valid;
    logic [1:0] src;
    logic [3:0] sel_map;
    logic       base_ins;
  } tag_req_t;

  typedef struct packed {
    logic        umc_en;
    logic [4:0]  umc_map;
    logic        uvid_en;
    logic [4:0]  uvid_map;
    logic        self_en;
    logic        uipm_en;
    logic [4:0]  uipm_map;
    logic [1:0]  per;
    logic        queue_lim;
    logic        tag_sel;
    logic [23:0] cnt;
    logic        tick;
    logic [31:0] rdata;
    fwd_res_t    fwd;
    logic        self_valid;
    logic        self_drop;
    logic        tag_valid;
    logic        tag_ins;
  } state_t;

endpackage

// File: unknown_frame_forward_regs.svh
`ifndef UNKNOWN_FRAME_FORWARD_REGS_SVH
`define UNKNOWN_FRAME_FORWARD_REGS_SVH

////////////////////////////////////////////////////////////////
// register indexes, byte address is index times four
`define IDX_UMC      8'h84
`define IDX_UVID     8'h85
`define IDX_SELF     8'h86
`define IDX_RATE     8'h87
`define ADDR_W       12

////////////////////////////////////////////////////////////////
// field positions
`define EN_BIT       5
`define SELF_BIT     6
`define QUEUE_BIT    3
`define TAGSEL_BIT   2
`define PER_LSB      4
`define PER_MSB      5
`define MAP_LSB      0
`define MAP_MSB      4
`define HI_LSB       6
`define HI_MSB       7

////////////////////////////////////////////////////////////////
// reset values, fixed read values, map mask and period codes
`define MAP_RST      5'h00
`define MAP_MASK     5'h17
`define PER_RST      2'h1
`define UMC_HI_RO    2'h1
`define PER_16       2'h0
`define PER_64       2'h1

////////////////////////////////////////////////////////////////
// timing
`define CLK_KHZ      25000
`define PER16_MS     16
`define PER64_MS     64
`define PER256_MS    256
`define CNT_W        24

`endif
